// ===== hdc_pkg.sv
// Constants, register map and types of the holdover DAC control block.
// Assumes a single 100 MHz system clock shared by every module.
package hdc_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int DAC_W  = 10;
  localparam int THR_W  = 6;
  localparam int ST_W   = 2;
  localparam int CNT_W  = 24;
  localparam int MULT_W = 16;
  // Register offsets.
  localparam logic [8:0] ADDR_MAN_HI   = 9'h14B;
  localparam logic [8:0] ADDR_MAN_LO   = 9'h14C;
  localparam logic [8:0] ADDR_TRIP_LO  = 9'h14D;
  localparam logic [8:0] ADDR_MULT_HI  = 9'h14E;
  localparam logic [8:0] ADDR_RATE_CNT = 9'h14F;
  localparam logic [8:0] ADDR_CFG      = 9'h150;
  localparam logic [8:0] ADDR_STATUS   = 9'h160;
  localparam logic [8:0] ADDR_MASK     = 9'h161;
  localparam logic [8:0] ADDR_DAC_HI   = 9'h162;
  localparam logic [8:0] ADDR_DAC_LO   = 9'h163;
  // Reset values.
  localparam logic [7:0] RST_MAN_HI   = 8'h06;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [7:0] RST_RATE_CNT = 8'h7F;
  // Field positions.
  localparam int TRACK_EN_BIT = 4;
  localparam int FORCE_BIT    = 3;
  localparam int MANSEL_BIT   = 2;
  localparam int VDET_BIT     = 2;
  localparam int MAN_HI_MSB   = 1;
  localparam int MULT_LSB     = 6;
  localparam int ST_LOW_BIT   = 0;
  localparam int ST_HIGH_BIT  = 1;
  // Tracking and trip scaling.
  localparam logic [9:0]  TRACK_START = 10'h200;
  localparam logic [10:0] DAC_SPAN    = 11'h400;
  localparam int          TRIP_SHIFT  = 4;
  localparam logic [15:0] MULT_BASE   = 16'h0004;
  localparam int          MULT_STEP   = 4;
  typedef enum logic [2:0] {
    HDC_IDLE  = 3'h1,
    HDC_TRACK = 3'h2,
    HDC_HOLD  = 3'h4
  } hdc_state_type;
endpackage

// ===== hdc_trip_if.sv
// Bundle between the control core and the trip comparator.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns
`default_nettype none
interface hdc_trip_if;
  logic [9:0] code;
  logic [5:0] low_thr;
  logic [5:0] high_thr;
  logic       eval;
  logic       low_hit;
  logic       high_hit;
  modport cmp (input code, low_thr, high_thr, eval, output low_hit, high_hit);
  modport ctl (output code, low_thr, high_thr, eval, input low_hit, high_hit);
endinterface
`default_nettype wire

// ===== hdc_rate_gen.sv
// Tracking update rate generator: one pulse per multiplier times count cycles.
// Assumes the multiplier and count come from registers on the same clock.
`timescale 1ns/1ns
`default_nettype none
module hdc_rate_gen
(
  // Clock and reset.
  input  wire logic       i_sys_clk,
  input  wire logic       i_resetn,
  // Rate settings.
  input  wire logic [1:0] i_mult_sel,
  input  wire logic [7:0] i_count,
  // Update pulse.
  output logic            o_tick
);
  logic [hdc_pkg::MULT_W-1:0] mult;
  logic [hdc_pkg::CNT_W-1:0]  interval;
  logic [hdc_pkg::CNT_W-1:0]  cnt_q;
  logic [hdc_pkg::CNT_W-1:0]  cnt_d;
  logic                       last;

  // Multiplier 4, 64, 1024 or 16384 is four shifted by four per step.
  assign mult     = hdc_pkg::MULT_BASE << (hdc_pkg::MULT_STEP * i_mult_sel); // R5
  // Both factors are widened first, so that 16384 times 255 does not wrap.
  assign interval = hdc_pkg::CNT_W'(mult) * hdc_pkg::CNT_W'(i_count); // R7
  // A zero count stops updates; a shrunk interval restarts the count.
  assign last     = (interval != '0) && (cnt_q >= interval - 1'b1);
  assign cnt_d    = (interval == '0 || last) ? '0 : cnt_q + 1'b1;

  // Interval counter and its pulse.
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cnt_q  <= '0;
      o_tick <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      o_tick <= last; // R7
    end
  end

  a_mult_top_step : assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // R5
    i_mult_sel == 2'h3 |-> mult == 16'h4000) else $error("multiplier decode wrong");
  a_tick_gap_min : assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // R7
    o_tick && $stable(interval) && interval > 24'h000001 |=> !o_tick)
    else $error("update pulses too close");
endmodule
`default_nettype wire

// ===== hdc_trip_cmp.sv
// Rail trip comparator: checks a DAC code against scaled low and high thresholds.
// Assumes eval pulses with the code that is about to become the tracked value.
`timescale 1ns/1ns
`default_nettype none
module hdc_trip_cmp
(
  // Clock and reset.
  input  wire logic i_sys_clk,
  input  wire logic i_resetn,
  // Comparator side of the bundle.
  hdc_trip_if.cmp   tif
);
  logic [10:0] low_lvl;
  logic [10:0] high_lvl;
  logic        low_now;
  logic        high_now;

  // Thresholds scaled to (field+1)*16 codes from ground and from the rail.
  // The field is widened before the shift, so that the top setting reaches 1024.
  assign low_lvl  = (11'(tif.low_thr) + 11'h001) << hdc_pkg::TRIP_SHIFT; // R11
  assign high_lvl = hdc_pkg::DAC_SPAN - ((11'(tif.high_thr) + 11'h001) << hdc_pkg::TRIP_SHIFT);
  assign low_now  = {1'b0, tif.code} <= low_lvl; // R3
  assign high_now = {1'b0, tif.code} >= high_lvl; // R4

  // Results are held between tracking updates.
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      tif.low_hit  <= 1'b0;
      tif.high_hit <= 1'b0;
    end
    else if (tif.eval)
    begin
      tif.low_hit  <= low_now; // R11
      tif.high_hit <= high_now;
    end
  end

  a_low_trip_hit : assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // R3
    tif.eval && ({1'b0, tif.code} <= 11'((tif.low_thr + 7'h01) * 16)) |=> tif.low_hit)
    else $error("low trip missed");
  a_high_trip_hit : assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // R4
    tif.eval && ({1'b0, tif.code} + 11'((tif.high_thr + 7'h01) * 16) >= 11'h400) |=> tif.high_hit)
    else $error("high trip missed");
endmodule
`default_nettype wire

// ===== hdc_core.sv
// Holdover DAC control: registers, tracking, manual select, rail trip and interrupt.
// Assumes a register master on i_sys_clk and a lock pin from another domain.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
// How it works
// R1: Manual code is upper two plus lower eight.
// R2: Manual select drives DAC with manual code.
// R3: Low trip at (code+1)/64 above ground.
// R4: High trip at (code+1)/64 below rail.
// R5: Multiplier field decodes to 4/64/1024/16384.
// R6: Rate count is eight bits, resets 127.
// R7: Update tracked value every multiplier times count.
// R8: Forced holdover uses manual or tracked value.
// R9: Track only when locked, start at 512.
// R10: Trip marks input invalid, raises switch event.
// R11: Compare tracked code to scaled thresholds.
module hdc_core
(
  // Clock and reset.
  input  wire logic       i_sys_clk,
  input  wire logic       i_resetn,
  // Register port.
  input  wire logic [8:0] i_addr,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rd_data,
  // Loop inputs.
  input  wire logic       i_pll_lock,
  input  wire logic [9:0] i_vtune_code,
  // DAC and holdover outputs.
  output logic      [9:0] o_dac_code,
  output logic            o_holdover,
  output logic            o_clkin_invalid,
  output logic            o_switch_event,
  output logic            o_irq
);
  // Register storage.
  logic [7:0] man_hi_q;
  logic [7:0] man_lo_q;
  logic [7:0] trip_lo_q;
  logic [7:0] mult_hi_q;
  logic [7:0] rate_cnt_q;
  logic [7:0] cfg_q;
  logic [hdc_pkg::ST_W-1:0] status_q;
  logic [hdc_pkg::ST_W-1:0] status_d;
  logic [hdc_pkg::ST_W-1:0] mask_q;
  logic [hdc_pkg::ST_W-1:0] ev_set;
  logic [7:0] rd_d;

  // Lock synchroniser and tracking state.
  logic lock_m_q;
  logic lock_s_q;
  logic [9:0] tracked_q;
  logic [9:0] tracked_d;
  logic [9:0] dac_d;
  logic trip_q;
  logic trip_d;
  hdc_pkg::hdc_state_type state_q;
  hdc_pkg::hdc_state_type state_d;

  // Decoded controls.
  logic [9:0] manual_dac_value;
  logic       track_en;
  logic       force_hold;
  logic       manual_select;
  logic       tune_rail_detect_enable;
  logic [1:0] tracking_rate_multiplier;
  logic       tick;
  logic       upd;
  logic       trip_now;
  logic       trip_event;

  // Write strobes per register.
  logic we_man_hi;
  logic we_man_lo;
  logic we_trip_lo;
  logic we_mult_hi;
  logic we_rate;
  logic we_cfg;
  logic we_mask;
  logic rd_status;

  hdc_trip_if tif ();

  // Address decode of writes and of the clearing read.
  assign we_man_hi  = i_wr && (i_addr == hdc_pkg::ADDR_MAN_HI);
  assign we_man_lo  = i_wr && (i_addr == hdc_pkg::ADDR_MAN_LO);
  assign we_trip_lo = i_wr && (i_addr == hdc_pkg::ADDR_TRIP_LO);
  assign we_mult_hi = i_wr && (i_addr == hdc_pkg::ADDR_MULT_HI);
  assign we_rate    = i_wr && (i_addr == hdc_pkg::ADDR_RATE_CNT);
  assign we_cfg     = i_wr && (i_addr == hdc_pkg::ADDR_CFG);
  assign we_mask    = i_wr && (i_addr == hdc_pkg::ADDR_MASK);
  assign rd_status  = i_rd && (i_addr == hdc_pkg::ADDR_STATUS);

  // Field extraction from the control registers.
  assign manual_dac_value = {man_hi_q[hdc_pkg::MAN_HI_MSB:0], man_lo_q}; // R1
  assign track_en         = man_hi_q[hdc_pkg::TRACK_EN_BIT];
  assign force_hold       = man_hi_q[hdc_pkg::FORCE_BIT];
  assign manual_select    = man_hi_q[hdc_pkg::MANSEL_BIT];
  assign tune_rail_detect_enable  = cfg_q[hdc_pkg::VDET_BIT];
  assign tracking_rate_multiplier = mult_hi_q[7:hdc_pkg::MULT_LSB]; // R5

  // Register writes; reset values follow the power-on defaults.
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      man_hi_q   <= hdc_pkg::RST_MAN_HI; // R8
      man_lo_q   <= hdc_pkg::RST_ZERO;
      trip_lo_q  <= hdc_pkg::RST_ZERO;
      mult_hi_q  <= hdc_pkg::RST_ZERO;
      rate_cnt_q <= hdc_pkg::RST_RATE_CNT; // R6
      cfg_q      <= hdc_pkg::RST_ZERO;
      mask_q     <= '0;
    end
    else
    begin
      if (we_man_hi)  man_hi_q   <= i_wr_data;
      if (we_man_lo)  man_lo_q   <= i_wr_data;
      if (we_trip_lo) trip_lo_q  <= i_wr_data;
      if (we_mult_hi) mult_hi_q  <= i_wr_data;
      if (we_rate)    rate_cnt_q <= i_wr_data; // R6
      if (we_cfg)     cfg_q      <= i_wr_data;
      if (we_mask)    mask_q     <= i_wr_data[hdc_pkg::ST_W-1:0];
    end
  end

  // Read mux; unmapped addresses read zero, reserved bits read zero.
  always_comb
  begin
    rd_d = '0;
    unique case (i_addr)
      hdc_pkg::ADDR_MAN_HI:   rd_d = man_hi_q;
      hdc_pkg::ADDR_MAN_LO:   rd_d = man_lo_q;
      hdc_pkg::ADDR_TRIP_LO:  rd_d = {2'h0, trip_lo_q[hdc_pkg::THR_W-1:0]};
      hdc_pkg::ADDR_MULT_HI:  rd_d = mult_hi_q;
      hdc_pkg::ADDR_RATE_CNT: rd_d = rate_cnt_q;
      hdc_pkg::ADDR_CFG:      rd_d = {1'b0, cfg_q[6:0]};
      hdc_pkg::ADDR_STATUS:   rd_d = {6'h00, status_q};
      hdc_pkg::ADDR_MASK:     rd_d = {6'h00, mask_q};
      hdc_pkg::ADDR_DAC_HI:   rd_d = {6'h00, o_dac_code[9:8]};
      hdc_pkg::ADDR_DAC_LO:   rd_d = o_dac_code[7:0];
      default:                rd_d = '0;
    endcase
  end

  // Read data stands in the cycle after the strobe only.
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_rd_data <= '0;
    else
      o_rd_data <= i_rd ? rd_d : '0;
  end

  // The lock pin crosses in through two flip-flops.
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      lock_m_q <= 1'b0;
      lock_s_q <= 1'b0;
    end
    else
    begin
      lock_m_q <= i_pll_lock;
      lock_s_q <= lock_m_q;
    end
  end

  hdc_rate_gen u_rate
  (
    .i_sys_clk  (i_sys_clk),
    .i_resetn   (i_resetn),
    .i_mult_sel (tracking_rate_multiplier),
    .i_count    (rate_cnt_q),
    .o_tick     (tick)
  );

  // Tracking follows the tuning code on each update while locked and in the track state.
  assign upd       = tick && (state_q == hdc_pkg::HDC_TRACK) && lock_s_q; // R9
  assign tracked_d = upd ? i_vtune_code : tracked_q; // R7

  // The comparator sees the code that the update is about to store.
  assign tif.code     = tracked_d; // R11
  assign tif.low_thr  = trip_lo_q[hdc_pkg::THR_W-1:0]; // R3
  assign tif.high_thr = mult_hi_q[hdc_pkg::THR_W-1:0]; // R4
  assign tif.eval     = upd; // R11

  hdc_trip_cmp u_cmp
  (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .tif       (tif)
  );

  // A new trip is a detector hit that is not yet latched.
  assign trip_now   = tune_rail_detect_enable && (tif.low_hit || tif.high_hit);
  assign trip_event = trip_now && !trip_q; // R10
  assign trip_d     = tune_rail_detect_enable && (trip_q || trip_now);
  assign ev_set     = trip_event ? {tif.high_hit, tif.low_hit} : '0;
  // Set wins over the clearing read.
  assign status_d   = (rd_status ? '0 : status_q) | ev_set;

  // Holdover entry: forced, or a latched rail trip; otherwise track or idle.
  always_comb
  begin
    if (force_hold || trip_d)
      state_d = hdc_pkg::HDC_HOLD; // R8
    else if (track_en)
      state_d = hdc_pkg::HDC_TRACK; // R9
    else
      state_d = hdc_pkg::HDC_IDLE;
  end

  // Manual select picks the programmed code, else the tracked one.
  assign dac_d = manual_select ? manual_dac_value : tracked_q; // R2 R8

  // Tracking, trip, status and control state.
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_q   <= hdc_pkg::HDC_IDLE;
      tracked_q <= hdc_pkg::TRACK_START; // R9
      trip_q    <= 1'b0;
      status_q  <= '0;
    end
    else
    begin
      state_q   <= state_d;
      tracked_q <= tracked_d;
      trip_q    <= trip_d;
      status_q  <= status_d;
    end
  end

  // Registered outputs.
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_dac_code      <= hdc_pkg::TRACK_START;
      o_holdover      <= 1'b0;
      o_clkin_invalid <= 1'b0;
      o_switch_event  <= 1'b0;
      o_irq           <= 1'b0;
    end
    else
    begin
      o_dac_code      <= dac_d; // R2
      o_holdover      <= (state_d == hdc_pkg::HDC_HOLD);
      o_clkin_invalid <= trip_d; // R10
      o_switch_event  <= trip_event; // R10
      o_irq           <= |(status_d & mask_q);
    end
  end

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);

  a_dac_manual_path : assert property ( // R2
    manual_select && !we_man_hi && !we_man_lo |=> o_dac_code == {$past(man_hi_q[1:0]), $past(man_lo_q)})
    else $error("manual code not on DAC");
  a_dac_tracked_path : assert property ( // R8
    !manual_select && !we_man_hi |=> o_dac_code == $past(tracked_q))
    else $error("tracked code not on DAC");
  a_track_unlock_hold : assert property ( // R9
    !lock_s_q |=> tracked_q == $past(tracked_q))
    else $error("tracking moved while unlocked");
  a_track_takes_code : assert property ( // R7
    tick && state_q == hdc_pkg::HDC_TRACK && lock_s_q |=> tracked_q == $past(i_vtune_code))
    else $error("update did not take tuning code");
  a_trip_raises_event : assert property ( // R10
    tune_rail_detect_enable && tif.low_hit && !trip_q |=> o_switch_event && o_clkin_invalid ##1 !o_switch_event)
    else $error("trip did not raise one switch event");

  // Register fields land where the DAC and the rate generator read them.
  a_manual_low_join : assert property ( // R1
    we_man_lo |=> manual_dac_value[7:0] == $past(i_wr_data))
    else $error("manual low byte not stored");
  a_manual_high_join : assert property ( // R1
    we_man_hi |=> manual_dac_value[9:8] == $past(i_wr_data[1:0]))
    else $error("manual upper bits not stored");
  a_rate_count_store : assert property ( // R6
    we_rate |=> rate_cnt_q == $past(i_wr_data))
    else $error("rate count not stored");

  // Holdover and idle freeze the tracked code; forcing raises holdover.
  a_hold_freezes : assert property ( // R8
    state_q == hdc_pkg::HDC_HOLD |=> tracked_q == $past(tracked_q))
    else $error("tracked code moved in holdover");
  a_force_holdover : assert property ( // R8
    force_hold |=> o_holdover)
    else $error("forced holdover not shown");
  a_idle_still : assert property ( // R9
    state_q == hdc_pkg::HDC_IDLE |=> tracked_q == $past(tracked_q))
    else $error("tracked code moved while disabled");
  a_lock_sync_delay : assert property ( // R9
    lock_s_q == $past(i_pll_lock, 2))
    else $error("lock not two stages behind pin");

  // A trip gives one short event and a sticky status bit.
  a_event_single : assert property ( // R10
    o_switch_event |=> !o_switch_event)
    else $error("switch event longer than one cycle");
  a_status_set_wins : assert property ( // R10
    trip_event |=> status_q != 2'h0)
    else $error("trip did not set status");
endmodule
`default_nettype wire

// ===== hdc_core_tb.sv
// Self-checking bench for the holdover DAC control block: registers, manual and tracked DAC, rail trip.
// Assumes the core alone on one 100 MHz clock, with the bench driving every port itself.
`timescale 1ns/1ns
`default_nettype none
module hdc_core_tb;
  logic       i_sys_clk = 1'b0;
  logic       i_resetn = 1'b0;
  logic [8:0] i_addr = 9'h000;
  logic [7:0] i_wr_data = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic       i_pll_lock = 1'b0;
  logic [9:0] i_vtune_code = 10'h155;
  logic [7:0] o_rd_data;
  logic [9:0] o_dac_code;
  logic       o_holdover;
  logic       o_clkin_invalid;
  logic       o_switch_event;
  logic       o_irq;
  logic       ramp = 1'b0;
  int         errors = 0;
  int         n_tests = 0;
  logic [9:0] v1;
  logic [9:0] v2;
  // Clock of 10 ns period.
  always #5 i_sys_clk = ~i_sys_clk;
  // Ramping tuning code, so that the step between two updates equals the interval.
  always @(posedge i_sys_clk)
    if (ramp)
      i_vtune_code <= i_vtune_code + 10'h001;
  hdc_core hdc_core_inst (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .i_pll_lock(i_pll_lock),
    .i_vtune_code(i_vtune_code), .o_dac_code(o_dac_code), .o_holdover(o_holdover),
    .o_clkin_invalid(o_clkin_invalid), .o_switch_event(o_switch_event), .o_irq(o_irq));
  // Prints the counts and the verdict, then stops.
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Compares a seen value with the expected one.
  task automatic check(input string nm, input logic [9:0] seen, input logic [9:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Lets n edges pass and settles just after the last.
  task automatic idle(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  // One-cycle register write.
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  // One-cycle register read; the data stand in the following cycle only.
  task automatic rd(input logic [8:0] a, input logic [7:0] exp);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    check("read data", {2'b00, o_rd_data}, {2'b00, exp});
  endtask
  // Waits, bounded, for the DAC code to move away from its present value.
  task automatic wait_dac;
    logic [9:0] old;
    int         k;
    old = o_dac_code;
    for (k = 0; k < 20000 && o_dac_code === old; k++)
      idle(1);
    if (o_dac_code === old)
    begin
      errors++;
      $display("FAIL dac wait expected change seen %h", old);
      tally_and_finish;
    end
  endtask
  // Waits, bounded, for the switch event pulse and checks that it lasts one cycle.
  task automatic wait_event;
    int k;
    for (k = 0; k < 200 && o_switch_event !== 1'b1; k++)
      idle(1);
    if (o_switch_event !== 1'b1)
    begin
      errors++;
      $display("FAIL switch event expected 1 seen %b", o_switch_event);
      tally_and_finish;
    end
    check("switch event", {9'h000, o_switch_event}, 10'h001);
    idle(1);
    check("event width", {9'h000, o_switch_event}, 10'h000);
  endtask
  // Main sequence of tests.
  initial
  begin
    idle(12);
    @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    i_pll_lock <= 1'b1;
    // Reset values of five registers, of an unmapped address and of the DAC.
    rd(hdc_pkg::ADDR_MAN_HI, hdc_pkg::RST_MAN_HI);
    rd(hdc_pkg::ADDR_MAN_LO, 8'h00);
    rd(hdc_pkg::ADDR_TRIP_LO, 8'h00);
    rd(hdc_pkg::ADDR_MULT_HI, 8'h00);
    rd(hdc_pkg::ADDR_RATE_CNT, 8'h7F);
    rd(9'h100, 8'h00);
    check("dac reset", o_dac_code, 10'h200);
    $display("test reset done");
    // Manual code at both ends of its range.
    wr(hdc_pkg::ADDR_MAN_LO, 8'hFF);
    wr(hdc_pkg::ADDR_MAN_HI, 8'h07);
    idle(2);
    check("manual max", o_dac_code, 10'h3FF);
    wr(hdc_pkg::ADDR_MAN_LO, 8'h00);
    wr(hdc_pkg::ADDR_MAN_HI, 8'h04);
    idle(2);
    check("manual min", o_dac_code, 10'h000);
    $display("test manual done");
    // Update interval for two multiplier settings.
    @(posedge i_sys_clk);
    i_vtune_code <= 10'h100;
    ramp <= 1'b1;
    wr(hdc_pkg::ADDR_MULT_HI, 8'h00);
    wr(hdc_pkg::ADDR_RATE_CNT, 8'h03);
    wr(hdc_pkg::ADDR_MAN_HI, 8'h10);
    // First change is the switch from manual to the tracked start code.
    wait_dac;
    wait_dac;
    v1 = o_dac_code;
    wait_dac;
    check("interval 4x3", o_dac_code - v1, 10'd12);
    wr(hdc_pkg::ADDR_MULT_HI, 8'h40);
    wr(hdc_pkg::ADDR_RATE_CNT, 8'h01);
    wait_dac;
    wait_dac;
    v1 = o_dac_code;
    wait_dac;
    check("interval 64x1", o_dac_code - v1, 10'd64);
    wr(hdc_pkg::ADDR_MULT_HI, 8'h00);
    wr(hdc_pkg::ADDR_RATE_CNT, 8'h02);
    $display("test rate done");
    // No tracking while unlocked.
    @(posedge i_sys_clk);
    i_pll_lock <= 1'b0;
    idle(20);
    v1 = o_dac_code;
    idle(40);
    check("unlocked hold", o_dac_code, v1);
    @(posedge i_sys_clk);
    i_pll_lock <= 1'b1;
    wait_dac;
    $display("test lock done");
    // Forced holdover freezes the tracked value, then selects the manual code.
    wr(hdc_pkg::ADDR_MAN_HI, 8'h18);
    idle(4);
    v1 = o_dac_code;
    idle(40);
    check("forced tracked", o_dac_code, v1);
    check("holdover", {9'h000, o_holdover}, 10'h001);
    wr(hdc_pkg::ADDR_MAN_LO, 8'h2A);
    wr(hdc_pkg::ADDR_MAN_HI, 8'h1E);
    idle(2);
    check("forced manual", o_dac_code, 10'h22A);
    $display("test force done");
    // Low trip at the exact boundary, interrupt unmasked.
    @(posedge i_sys_clk);
    ramp <= 1'b0;
    @(posedge i_sys_clk);
    i_vtune_code <= 10'd64;
    wr(hdc_pkg::ADDR_MASK, 8'h03);
    wr(hdc_pkg::ADDR_TRIP_LO, 8'h03);
    wr(hdc_pkg::ADDR_MULT_HI, 8'h01);
    wr(hdc_pkg::ADDR_MAN_HI, 8'h10);
    wr(hdc_pkg::ADDR_CFG, 8'h04);
    wait_event;
    v2 = {o_holdover, o_clkin_invalid, o_irq, 7'h00};
    check("low trip flags", v2, 10'h380);
    check("low trip dac", o_dac_code, 10'd64);
    rd(hdc_pkg::ADDR_STATUS, 8'h01);
    check("irq cleared", {9'h000, o_irq}, 10'h000);
    $display("test low trip done");
    // High trip at the exact boundary, interrupt masked out.
    wr(hdc_pkg::ADDR_CFG, 8'h00);
    idle(2);
    check("trip released", {9'h000, o_holdover}, 10'h000);
    @(posedge i_sys_clk);
    i_vtune_code <= 10'd992;
    // Let one update refresh the comparator before the detector comes back on.
    wait_dac;
    wr(hdc_pkg::ADDR_MASK, 8'h01);
    wr(hdc_pkg::ADDR_CFG, 8'h04);
    wait_event;
    v2 = {o_holdover, o_clkin_invalid, o_irq, 7'h00};
    check("high trip flags", v2, 10'h300);
    check("high trip dac", o_dac_code, 10'd992);
    rd(hdc_pkg::ADDR_STATUS, 8'h02);
    rd(hdc_pkg::ADDR_STATUS, 8'h00);
    $display("test high trip done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
